//--- mdsd_pkg.sv
/*
 * Shared constants for the multiply, divide and shift datapath:
 * operation codes, reset values, saturation limits and divider timing.
 * Assumes nothing of its surroundings; imported by scoped names only.
 */
package mdsd_pkg;

    // Operation codes issued by instruction decode
    typedef enum logic [3:0] {
        OP_LONG_PRODUCT = 4'b0000,
        OP_SIGNED_WIDE = 4'b0001,
        OP_UNSIGNED_WIDE = 4'b0010,
        OP_WORD_PRODUCT_SUM = 4'b0011,
        OP_LONG_PRODUCT_SUM = 4'b0100,
        OP_LOGICAL_VAR_SHIFT = 4'b0101,
        OP_ARITH_VAR_SHIFT = 4'b0110,
        OP_SATURATE_FLAG_ON = 4'b0111,
        OP_SATURATE_FLAG_OFF = 4'b1000,
        OP_COUNT_DOWN_TEST = 4'b1001,
        OP_CLEAR_ACCUM = 4'b1010
    } mdsd_op_t;

    // Reset values
    localparam logic [31:0] ACCUM_RST = 32'h0000_0000;
    localparam logic SAT_RST = 1'b0;
    localparam logic TRUE_RST = 1'b0;

    // Word product-sum saturation limits (signed 32-bit)
    localparam logic [31:0] SAT32_MAX = 32'h7fff_ffff;
    localparam logic [31:0] SAT32_MIN = 32'h8000_0000;

    // Long product-sum saturation limits (signed 48-bit, at 66 bits)
    localparam logic signed [65:0] SAT48_MAX = 66'sh0_0000_7fff_ffff_ffff;
    localparam logic signed [65:0] SAT48_MIN = -66'sh0_0000_8000_0000_0000;

    // Shift count field width
    localparam int unsigned SHIFT_CNT_W = 6;

    // Divider timing: whole division in clock periods, quotient steps
    localparam logic [5:0] DIV_CYCLES = 6'd39;
    localparam logic [5:0] DIV_STEPS = 6'd32;
    localparam logic [5:0] DIV_LAST_STEP = DIV_CYCLES - DIV_STEPS + 6'd1;

endpackage

//--- mdsd_divider.sv
/*
 * Peripheral divide unit: 64/32 or 32/32 unsigned restoring division.
 * Assumes a synchronised active-low reset copy from the top module and
 * operands held stable only in the cycle that start is high.
 */
`timescale 1ns/10ps
`default_nettype none

module mdsd_divider (
    input wire logic clk, // Processor clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic start, // Start pulse, ignored while busy
    input wire logic wide, // 1: 64-bit dividend, 0: 32-bit
    input wire logic [31:0] dividend_hi, // Dividend upper word
    input wire logic [31:0] dividend_lo, // Dividend lower word
    input wire logic [31:0] divisor, // Divisor, always 32-bit
    output logic busy, // Division in progress
    output logic done, // One-cycle completion pulse
    output logic error, // Divide by zero or quotient overflow
    output logic [31:0] quotient, // Quotient
    output logic [31:0] remainder // Remainder
);

    logic [63:0] work_q;
    logic [31:0] dvsr_q;
    logic [5:0] cnt_q;
    logic [64:0] shifted;
    logic [32:0] trial;

    // One restoring step: shift left, try subtract divisor
    assign shifted = {work_q, 1'b0};
    assign trial = shifted[64:32] - {1'b0, dvsr_q};

    // Working register and cycle count; steps run first, then a fixed tail
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_q <= 64'h0000_0000_0000_0000;
            dvsr_q <= 32'h0000_0000;
            cnt_q <= 6'h00;
            error <= 1'b0;
        end else if (start && cnt_q == 6'h00) begin
            work_q <= {wide ? dividend_hi : 32'h0000_0000, dividend_lo};
            dvsr_q <= divisor;
            cnt_q <= mdsd_pkg::DIV_CYCLES;
            error <= (divisor == 32'h0000_0000) || (wide && dividend_hi >= divisor);
        end else if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q >= mdsd_pkg::DIV_LAST_STEP) begin
                work_q <= trial[32] ? shifted[63:0] : {trial[31:0], shifted[31:1], 1'b1};
            end
        end
    end

    // Done pulse after the fixed count, independent of data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= (cnt_q == 6'h01);
        end
    end

    assign busy = (cnt_q != 6'h00);
    assign quotient = work_q[31:0];
    assign remainder = work_q[63:32];

    a_div_rem_below: assert property (@(posedge clk) disable iff (!rst_n)
        done && !error |-> remainder < dvsr_q)
        else $error("remainder not below divisor");

endmodule

`default_nettype wire

//--- mdsd_datapath.sv
/*
 * Multiply, product-sum, variable shift and count-down datapath with
 * the accumulator pair, saturation flag, true flag and divide unit.
 * Assumes decode presents one operation per cycle on op_valid, with
 * operands from the general registers on the same clock.
 */
// Summary of operation
// - Long product multiplies two 32-bit operands into the low accumulator.
// - Wide product, signed or unsigned, puts the full 64-bit result in the accumulator pair.
// - The divide unit finishes in 39 clocks with a 32-bit quotient and remainder.
// - The dividend is 64 or 32 bits wide, the divisor always 32 bits.
// - The divide unit runs as a peripheral, apart from the step divide instructions.
// - Word product-sum without saturation adds a signed 16x16 product to the 64-bit pair.
// - Word product-sum with saturation clamps the low word and flags overflow in bit 0 of the high word.
// - Long product-sum adds a 32x32 product into the 64-bit pair.
// - Long product-sum with saturation clamps to signed 48 bits, sign-extended to 64.
// - Logical and arithmetic variable shifts take their count from another register.
// - The count is 6-bit signed and positive values shift left.
// - Dedicated operations set and clear the saturation flag directly.
`timescale 1ns/10ps
`default_nettype none

module mdsd_datapath (
    input wire logic ref_clk, // 250 MHz processor clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic op_valid, // Operation issued this cycle
    input wire logic [3:0] op_code, // Operation, mdsd_op_t encoding
    input wire logic [31:0] src_a, // First operand register
    input wire logic [31:0] src_b, // Second operand or shift count
    input wire logic div_start, // Start peripheral division
    input wire logic div_wide, // 64-bit dividend select
    input wire logic [31:0] div_dividend_hi, // Dividend upper word
    input wire logic [31:0] div_dividend_lo, // Dividend lower word
    input wire logic [31:0] div_divisor, // Divisor
    output logic res_valid, // General register result valid pulse
    output logic [31:0] res_data, // General register result
    output logic [31:0] accum_high, // High accumulator register
    output logic [31:0] accum_low, // Low accumulator register
    output logic sat_flag, // Saturation flag of status_word
    output logic true_flag, // True flag of status_word
    output logic div_busy, // Divider running
    output logic div_done, // Divider done pulse
    output logic div_error, // Divide by zero or overflow
    output logic [31:0] div_quotient, // Quotient
    output logic [31:0] div_remainder // Remainder
);

    // Variable shift: signed 6-bit count, left when positive
    function automatic logic [31:0] var_shift(input logic [31:0] val, input logic [5:0] cnt,
                                              input logic arith);
        logic [63:0] ext;
        logic [5:0] mag;
        ext = {arith ? {32{val[31]}} : 32'h0000_0000, val};
        mag = 6'h00 - cnt;
        if (!cnt[mdsd_pkg::SHIFT_CNT_W-1]) begin
            var_shift = val << cnt;
        end else begin
            var_shift = 32'(ext >> mag);
            if (arith) begin
                var_shift = 32'($signed(ext) >>> mag);
            end
        end
    endfunction

    logic rst_meta_q;
    logic rst_n_q;
    mdsd_pkg::mdsd_op_t op;
    logic [63:0] acc;
    logic signed [63:0] prod_s;
    logic [63:0] prod_u;
    logic signed [31:0] prod_w;
    logic [32:0] wsum;
    logic w_ovf;
    logic signed [65:0] lsum;
    logic [63:0] acc_d;
    logic acc_we;

    // Reset release through two flops; assertion is still immediate
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    assign op = mdsd_pkg::mdsd_op_t'(op_code);
    assign acc = {accum_high, accum_low};

    // Products: the signed 32x32 product serves long, signed wide and long-sum forms; unsigned wide has its own
    assign prod_s = $signed(src_a) * $signed(src_b);
    assign prod_u = {32'h0000_0000, src_a} * {32'h0000_0000, src_b};
    assign prod_w = $signed(src_a[15:0]) * $signed(src_b[15:0]);

    // Word sum at 33 bits catches signed 32-bit overflow
    assign wsum = {accum_low[31], accum_low} + {prod_w[31], prod_w};
    assign w_ovf = wsum[32] ^ wsum[31];

    // Long sum at 66 bits so the 48-bit clamp never wraps first
    assign lsum = $signed({{2{acc[63]}}, acc}) + $signed({{2{prod_s[63]}}, prod_s});

    // Next accumulator value per operation
    always_comb begin
        acc_d = acc;
        acc_we = op_valid;
        case (op)
            mdsd_pkg::OP_LONG_PRODUCT: begin
                acc_d = {accum_high, prod_s[31:0]};
            end
            mdsd_pkg::OP_SIGNED_WIDE: begin
                acc_d = prod_s;
            end
            mdsd_pkg::OP_UNSIGNED_WIDE: begin
                acc_d = prod_u;
            end
            mdsd_pkg::OP_WORD_PRODUCT_SUM: begin
                if (!sat_flag) begin
                    acc_d = acc + {{32{prod_w[31]}}, prod_w};
                end else if (w_ovf) begin
                    acc_d = {accum_high | 32'h0000_0001,
                             wsum[32] ? mdsd_pkg::SAT32_MIN : mdsd_pkg::SAT32_MAX};
                end else begin
                    acc_d = {accum_high, wsum[31:0]};
                end
            end
            mdsd_pkg::OP_LONG_PRODUCT_SUM: begin
                acc_d = lsum[63:0];
                if (sat_flag && lsum > mdsd_pkg::SAT48_MAX) begin
                    acc_d = mdsd_pkg::SAT48_MAX[63:0];
                end else if (sat_flag && lsum < mdsd_pkg::SAT48_MIN) begin
                    acc_d = mdsd_pkg::SAT48_MIN[63:0];
                end
            end
            mdsd_pkg::OP_CLEAR_ACCUM: begin
                acc_d = {mdsd_pkg::ACCUM_RST, mdsd_pkg::ACCUM_RST};
            end
            default: begin
                acc_we = 1'b0;
            end
        endcase
    end

    // Accumulator pair
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            accum_high <= mdsd_pkg::ACCUM_RST;
            accum_low <= mdsd_pkg::ACCUM_RST;
        end else if (acc_we) begin
            accum_high <= acc_d[63:32];
            accum_low <= acc_d[31:0];
        end
    end

    // Saturation flag: direct set and clear, no status word load
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sat_flag <= mdsd_pkg::SAT_RST;
        end else if (op_valid && op == mdsd_pkg::OP_SATURATE_FLAG_ON) begin
            sat_flag <= 1'b1;
        end else if (op_valid && op == mdsd_pkg::OP_SATURATE_FLAG_OFF) begin
            sat_flag <= 1'b0;
        end
    end

    // General register results: shifts and count-down
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            res_valid <= 1'b0;
            res_data <= 32'h0000_0000;
            true_flag <= mdsd_pkg::TRUE_RST;
        end else begin
            res_valid <= 1'b0;
            if (op_valid && op == mdsd_pkg::OP_LOGICAL_VAR_SHIFT) begin
                res_valid <= 1'b1;
                res_data <= var_shift(src_a, src_b[5:0], 1'b0);
            end else if (op_valid && op == mdsd_pkg::OP_ARITH_VAR_SHIFT) begin
                res_valid <= 1'b1;
                res_data <= var_shift(src_a, src_b[5:0], 1'b1);
            end else if (op_valid && op == mdsd_pkg::OP_COUNT_DOWN_TEST) begin
                res_valid <= 1'b1;
                res_data <= src_a - 32'h0000_0001;
                true_flag <= (src_a == 32'h0000_0001);
            end
        end
    end

    logic busy_w;
    logic done_w;
    logic err_w;
    logic [31:0] quo_w;
    logic [31:0] rem_w;

    // Divider is its own peripheral; step divides never reach it
    mdsd_divider u_div (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .start(div_start),
        .wide(div_wide),
        .dividend_hi(div_dividend_hi),
        .dividend_lo(div_dividend_lo),
        .divisor(div_divisor),
        .busy(busy_w),
        .done(done_w),
        .error(err_w),
        .quotient(quo_w),
        .remainder(rem_w)
    );

    // Divider results re-timed so every output leaves a flop here
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_busy <= 1'b0;
            div_done <= 1'b0;
            div_error <= 1'b0;
            div_quotient <= 32'h0000_0000;
            div_remainder <= 32'h0000_0000;
        end else begin
            div_busy <= busy_w;
            div_done <= done_w;
            div_error <= err_w;
            div_quotient <= quo_w;
            div_remainder <= rem_w;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_q);

    a_long_product: assert property (op_valid && op == mdsd_pkg::OP_LONG_PRODUCT |=>
        accum_low == $past(src_a) * $past(src_b) && $stable(accum_high))
        else $error("long product wrong");
    a_unsigned_wide: assert property (op_valid && op == mdsd_pkg::OP_UNSIGNED_WIDE |=>
        {accum_high, accum_low} == {32'h0000_0000, $past(src_a)} * {32'h0000_0000, $past(src_b)})
        else $error("unsigned wide product wrong");
    // Done flop rises 39 edges after the start edge, so it is sampled high one edge later
    a_div_timing: assert property (div_start && !busy_w |-> ##40 done_w)
        else $error("divide not done in 39 clocks");
    a_word_sum: assert property (op_valid && op == mdsd_pkg::OP_WORD_PRODUCT_SUM && !sat_flag |=>
        {accum_high, accum_low} == $past(acc) + {{32{$past(prod_w[31])}}, $past(prod_w)})
        else $error("word product-sum wrong");
    a_word_sat_flag: assert property (op_valid && op == mdsd_pkg::OP_WORD_PRODUCT_SUM && sat_flag && w_ovf |=>
        accum_high[0] && accum_low == ($past(prod_w[31]) ? mdsd_pkg::SAT32_MIN : mdsd_pkg::SAT32_MAX))
        else $error("word saturation missing");
    a_long_sat_range: assert property (op_valid && op == mdsd_pkg::OP_LONG_PRODUCT_SUM && sat_flag |=>
        accum_high[31:15] == {17{accum_high[15]}})
        else $error("long saturation out of 48-bit range");
    a_shift_left: assert property (op_valid && op == mdsd_pkg::OP_LOGICAL_VAR_SHIFT && !src_b[5] |=>
        res_valid && res_data == $past(src_a) << $past(src_b[4:0]))
        else $error("left shift wrong");
    a_shift_right: assert property (op_valid && op == mdsd_pkg::OP_ARITH_VAR_SHIFT && src_b[5] |=>
        res_data == 32'($signed($past(src_a)) >>> (6'h00 - $past(src_b[5:0]))))
        else $error("arithmetic right shift wrong");
    a_sat_set_clear: assert property (op_valid && op == mdsd_pkg::OP_SATURATE_FLAG_OFF |=> !sat_flag
        ##1 (sat_flag == $past(op_valid && op == mdsd_pkg::OP_SATURATE_FLAG_ON)))
        else $error("saturation flag control wrong");
    a_count_down: assert property (op_valid && op == mdsd_pkg::OP_COUNT_DOWN_TEST |=>
        res_data == $past(src_a) - 32'h0000_0001 && true_flag == (res_data == 32'h0000_0000))
        else $error("count-down-and-test wrong");

endmodule

`default_nettype wire

//--- mdsd_decode_model.sv
/*
 * Behavioural model of instruction decode and the register file that
 * issue one operation at a time to the datapath.
 * Assumes the caller invokes issue from a procedural thread.
 */
`timescale 1ns/10ps
`default_nettype none

module mdsd_decode_model (
    input wire logic ref_clk, // Processor clock
    output var logic op_valid, // Operation strobe
    output var logic [3:0] op_code, // Operation code
    output var logic [31:0] src_a, // First operand
    output var logic [31:0] src_b // Second operand or count
);
    // Idle at time zero, nothing issued
    initial begin
        op_valid = 1'b0;
        op_code = 4'h0;
        src_a = 32'h0000_0000;
        src_b = 32'h0000_0000;
    end

    // One op per call; returns at the taking edge
    task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code <= op;
        src_a <= a;
        src_b <= b;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        op_code <= ~op; // Stale fields never match the last op
        src_a <= ~a;
        src_b <= ~b;
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench for the multiply, divide and shift datapath.
 * Assumes mdsd_pkg and mdsd_datapath are compiled before this file.
 */
`timescale 1ns/10ps
`default_nettype none
`define MDSD_CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    typedef struct {
        logic [3:0] op;
        logic [31:0] a, b, hi, lo, res;
        logic sat, tf;
    } mdsd_row_t;

    logic ref_clk, resetn, div_start, div_wide;
    logic [31:0] div_dividend_hi, div_dividend_lo, div_divisor;
    logic op_valid, res_valid, sat_flag, true_flag, div_busy, div_done, div_error;
    logic [3:0] op_code;
    logic [31:0] src_a, src_b, res_data, accum_high, accum_low, div_quotient, div_remainder;
    int failures = 0;
    int checks_done = 0;

    // Rows run in order; each sees the previous row's accumulator
    mdsd_row_t rows[25] = '{
        '{4'h9, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b1},
        '{4'h9, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h0, 32'h0001_0003, 32'h0001_0002, 32'h0000_0000, 32'h0005_0006, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h1, 32'hffff_fffe, 32'h0000_0003, 32'hffff_ffff, 32'hffff_fffa, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h2, 32'hffff_fffe, 32'h0000_0003, 32'h0000_0002, 32'hffff_fffa, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'ha, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h3, 32'h0000_8000, 32'h0000_0002, 32'hffff_ffff, 32'hffff_0000, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h3, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_0000, 32'h3ffe_0001, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h4, 32'h0001_0000, 32'h0001_0000, 32'h0000_0001, 32'h3ffe_0001, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'hb, 32'h0001_0000, 32'h0001_0000, 32'h0000_0001, 32'h3ffe_0001, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h5, 32'h8000_0001, 32'h0000_0004, 32'h0000_0001, 32'h3ffe_0001, 32'h0000_0010, 1'b0, 1'b0},
        '{4'h5, 32'h8000_0001, 32'h0000_003c, 32'h0000_0001, 32'h3ffe_0001, 32'h0800_0000, 1'b0, 1'b0},
        '{4'h6, 32'h8000_0001, 32'h0000_003c, 32'h0000_0001, 32'h3ffe_0001, 32'hf800_0000, 1'b0, 1'b0},
        '{4'h5, 32'h8000_0001, 32'h0000_0020, 32'h0000_0001, 32'h3ffe_0001, 32'h0000_0000, 1'b0, 1'b0},
        '{4'h6, 32'h8000_0001, 32'h0000_0020, 32'h0000_0001, 32'h3ffe_0001, 32'hffff_ffff, 1'b0, 1'b0},
        '{4'h5, 32'h0000_0001, 32'hffff_ffc1, 32'h0000_0001, 32'h3ffe_0001, 32'h0000_0002, 1'b0, 1'b0},
        '{4'h7, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h3ffe_0001, 32'h0000_0002, 1'b1, 1'b0},
        '{4'ha, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 1'b1, 1'b0},
        '{4'h3, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_0000, 32'h3fff_0001, 32'h0000_0002, 1'b1, 1'b0},
        '{4'h3, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_0000, 32'h7ffe_0002, 32'h0000_0002, 1'b1, 1'b0},
        '{4'h3, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_0001, 32'h7fff_ffff, 32'h0000_0002, 1'b1, 1'b0},
        '{4'ha, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 1'b1, 1'b0},
        '{4'h4, 32'h7fff_ffff, 32'h7fff_ffff, 32'h0000_7fff, 32'hffff_ffff, 32'h0000_0002, 1'b1, 1'b0},
        '{4'h8, 32'h0000_0000, 32'h0000_0000, 32'h0000_7fff, 32'hffff_ffff, 32'h0000_0002, 1'b0, 1'b0},
        '{4'h3, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_8000, 32'h3fff_0000, 32'h0000_0002, 1'b0, 1'b0}
    };

    mdsd_decode_model decode (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code), .src_a(src_a),
        .src_b(src_b));

    mdsd_datapath DUT (.ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
        .src_a(src_a), .src_b(src_b), .div_start(div_start), .div_wide(div_wide),
        .div_dividend_hi(div_dividend_hi), .div_dividend_lo(div_dividend_lo), .div_divisor(div_divisor),
        .res_valid(res_valid), .res_data(res_data), .accum_high(accum_high), .accum_low(accum_low),
        .sat_flag(sat_flag), .true_flag(true_flag), .div_busy(div_busy), .div_done(div_done),
        .div_error(div_error), .div_quotient(div_quotient), .div_remainder(div_remainder));

    // Free-running 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Verdict and end of run, shared with the watchdog
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One division; a second start at mid-run must be ignored
    task automatic div_run(input logic w, input logic [31:0] hi, input logic [31:0] lo, input logic [31:0] dv,
        input logic [31:0] q, input logic [31:0] r, input logic err);
        int n;
        @(posedge ref_clk);
        div_start <= 1'b1;
        div_wide <= w;
        div_dividend_hi <= hi;
        div_dividend_lo <= lo;
        div_divisor <= dv;
        @(posedge ref_clk);
        div_start <= 1'b0;
        div_dividend_hi <= ~hi; // Operands only count on the start edge
        div_dividend_lo <= ~lo;
        div_divisor <= 32'h0000_0000;
        n = 0;
        while (div_done !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            div_start <= (n == 9);
            #1;
            n++;
            if (n == 20) `MDSD_CHECK(div_busy, 1'b1)
        end
        `MDSD_CHECK(n, 40)
        `MDSD_CHECK(div_error, err)
        if (!err) begin
            `MDSD_CHECK(div_quotient, q)
            `MDSD_CHECK(div_remainder, r)
        end
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        div_start = 1'b0;
        div_wide = 1'b0;
        div_dividend_hi = 32'h0000_0000;
        div_dividend_lo = 32'h0000_0000;
        div_divisor = 32'h0000_0001;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (rows[i]) begin
            decode.issue(rows[i].op, rows[i].a, rows[i].b);
            #1;
            `MDSD_CHECK(accum_high, rows[i].hi)
            `MDSD_CHECK(accum_low, rows[i].lo)
            `MDSD_CHECK(res_data, rows[i].res)
            `MDSD_CHECK(res_valid, rows[i].op inside {4'h5, 4'h6, 4'h9})
            `MDSD_CHECK(sat_flag, rows[i].sat)
            `MDSD_CHECK(true_flag, rows[i].tf)
        end
        // Narrow, wide, quotient overflow and zero divisor
        div_run(1'b0, 32'h0000_0000, 32'h0000_0064, 32'h0000_0007, 32'h0000_000e, 32'h0000_0002, 1'b0);
        div_run(1'b1, 32'h0000_0001, 32'h0000_0000, 32'h0000_0002, 32'h8000_0000, 32'h0000_0000, 1'b0);
        div_run(1'b1, 32'h0000_0005, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000, 32'h0000_0000, 1'b1);
        div_run(1'b0, 32'h0000_0000, 32'h0000_0009, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1);
        // Reset in mid-run clears the accumulator pair and flags
        @(posedge ref_clk);
        resetn <= 1'b0;
        #1;
        `MDSD_CHECK({accum_high, accum_low, res_data}, 96'h0)
        `MDSD_CHECK({sat_flag, true_flag, div_error}, 3'b000)
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        decode.issue(4'h9, 32'h0000_0002, 32'h0000_0000);
        #1;
        `MDSD_CHECK({true_flag, res_data}, {1'b0, 32'h0000_0001})
        results();
    end

    // Watchdog, well past the few hundred cycles the tests need
    initial begin
        #80000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
